// ### rtl/rvc_regulator_vbus_control.sv
// module: control register, bus-power status, interrupt and reset request
`timescale 1ns/1ps
`default_nettype none
module rvc_regulator_vbus_control #(
  // depth of the bus-power pin synchroniser
  parameter int SYNC_STAGES = rvc_pkg::SYNC_STAGES
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // special-function register port
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  // bus-power pin and system hooks
  input  wire logic       i_bus_power,
  input  wire logic       i_irq_enable,
  input  wire logic       i_usb_reset_source,
  // regulator and system outputs
  output logic            o_regulator_off_select,
  output logic            o_regulator_on_select,
  output logic            o_regulator_low_power_select,
  output logic            o_bus_power_irq,
  output logic            o_bus_power_reset_req
);
  // ===========================================================================
  // state
  // sync is the pin chain, newest sample in bit 0; the other fields
  // mirror the writable control bits of the register
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic       off;
    logic       pol;
    logic       lowpwr;
  } rvc_state_t;

  rvc_state_t st;
  rvc_state_t next_st;
  logic       bus_power_level;
  logic       match;
  logic       ctrl_hit;
  logic       ctrl_wr;
  logic [7:0] ctrl_view;

  // ===========================================================================
  // elaboration checks
  // a single flop would let a metastable pin value reach the match logic
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("bus-power synchroniser needs at least two stages");
  end
  // every stored or shown field must sit inside the register byte
  if (rvc_pkg::OFF_BIT > 7 || rvc_pkg::LEVEL_BIT > 7 ||
      rvc_pkg::POL_BIT > 7 || rvc_pkg::LOWPWR_BIT > 7) begin : g_bad_field
    $error("control field lies outside the register byte");
  end
  // reserved bits must not overlap the live fields
  if ((rvc_pkg::RESERVED_MASK >> rvc_pkg::LOWPWR_BIT) != 8'h00) begin : g_bad_mask
    $error("reserved mask overlaps a live control field");
  end

  // ===========================================================================
  // register decode
  // a read is selected by address alone; a write also needs the strobe
  assign ctrl_hit = (i_sfr_addr == rvc_pkg::CTRL_ADDR);
  assign ctrl_wr  = i_sfr_wr && ctrl_hit;

  assign bus_power_level = st.sync[SYNC_STAGES-1];
  assign match           = (bus_power_level == st.pol);

  always_comb begin
    next_st      = st;
    // the pin shifts in on every clock, write or not
    next_st.sync = {st.sync[SYNC_STAGES-2:0], i_bus_power};
    if (ctrl_wr) begin
      // bit 6 and bits 3..0 are not stored
      next_st.off    = i_sfr_wdata[rvc_pkg::OFF_BIT];
      next_st.pol    = i_sfr_wdata[rvc_pkg::POL_BIT];
      next_st.lowpwr = i_sfr_wdata[rvc_pkg::LOWPWR_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // stored fields take their reset value; the pin chain clears
      st.sync   <= '0;
      st.off    <= rvc_pkg::CTRL_RESET[rvc_pkg::OFF_BIT];
      st.pol    <= rvc_pkg::CTRL_RESET[rvc_pkg::POL_BIT];
      st.lowpwr <= rvc_pkg::CTRL_RESET[rvc_pkg::LOWPWR_BIT];
    end else begin
      st <= next_st;
    end
  end

  // ===========================================================================
  // outputs
  // read view of the control register, built bit by bit
  for (genvar b = 0; b < 8; b++) begin : g_view
    if (b == rvc_pkg::OFF_BIT) begin : g_off
      assign ctrl_view[b] = st.off;
    end else if (b == rvc_pkg::LEVEL_BIT) begin : g_level
      assign ctrl_view[b] = bus_power_level;
    end else if (b == rvc_pkg::POL_BIT) begin : g_pol
      assign ctrl_view[b] = st.pol;
    end else if (b == rvc_pkg::LOWPWR_BIT) begin : g_lowpwr
      assign ctrl_view[b] = st.lowpwr;
    end else begin : g_reserved
      assign ctrl_view[b] = 1'b0;
    end
  end

  always_comb begin
    o_sfr_rdata = 8'h00;
    if (ctrl_hit) begin
      o_sfr_rdata = ctrl_view;
    end
  end

  // interrupt and reset request are plain levels of the match: there is
  // no pending flag to clear, so software silences them by flipping the
  // polarity or dropping i_irq_enable or i_usb_reset_source; both trail the pin by the sync depth
  assign o_regulator_off_select       = st.off;
  assign o_regulator_on_select        = ~st.off;
  assign o_regulator_low_power_select = st.lowpwr;
  assign o_bus_power_irq              = i_irq_enable & match;
  assign o_bus_power_reset_req        = i_usb_reset_source & match;

  // ===========================================================================
  // assertions
  a_off_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_sfr_wr && i_sfr_addr == rvc_pkg::CTRL_ADDR) |=>
      (o_regulator_off_select == $past(i_sfr_wdata[7]) && o_regulator_on_select != o_regulator_off_select))
    else $error("regulator off select does not follow write");
  a_level_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##2 (bus_power_level == $past(i_bus_power, 2)))
    else $error("bus power level not following input");
  a_irq_match: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_bus_power_irq == (i_irq_enable && (st.sync[1] == st.pol)))
    else $error("interrupt does not match polarity");
  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_irq_enable && $stable(st.pol) && $stable(st.sync[1]) && $past(o_bus_power_irq))
      |-> o_bus_power_irq)
    else $error("interrupt dropped while still matching");
  a_reset_req: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_bus_power_reset_req == (i_usb_reset_source && match))
    else $error("reset request wrong");
  a_lowpwr_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_sfr_wr && i_sfr_addr == rvc_pkg::CTRL_ADDR) |=>
      o_regulator_low_power_select == $past(i_sfr_wdata[4]))
    else $error("low power select does not follow write");
  a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_sfr_rdata & rvc_pkg::RESERVED_MASK) == 8'h00)
    else $error("reserved bits read nonzero");
  a_hold_other: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(i_sfr_wr && i_sfr_addr == rvc_pkg::CTRL_ADDR) |=> $stable(st.off) && $stable(st.pol))
    else $error("control changed without write");

  // read view, gating and following of the level outputs
  a_on_inverse: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_regulator_on_select == !o_regulator_off_select)
    else $error("regulator on select is not the inverse of off select");
  a_pol_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr |=> st.pol == $past(i_sfr_wdata[rvc_pkg::POL_BIT]))
    else $error("match polarity does not follow write");
  a_irq_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_irq_enable |-> !o_bus_power_irq)
    else $error("interrupt raised while disabled");
  a_irq_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_irq_enable && bus_power_level == st.pol) |-> o_bus_power_irq)
    else $error("interrupt missing while matching");
  a_irq_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (bus_power_level != st.pol) |-> !o_bus_power_irq)
    else $error("interrupt held without a match");
  a_reset_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (bus_power_level != st.pol) |-> !o_bus_power_reset_req)
    else $error("reset request without a match");
  a_reset_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_usb_reset_source && bus_power_level == st.pol) |-> o_bus_power_reset_req)
    else $error("reset request missing while matching");
  a_sync_first: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##1 (st.sync[0] == $past(i_bus_power)))
    else $error("pin not sampled into the synchroniser");
  a_level_read: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_hit |-> o_sfr_rdata[rvc_pkg::LEVEL_BIT] == bus_power_level)
    else $error("status bit does not show the bus power level");
  a_ctrl_read: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_hit |-> (o_sfr_rdata[rvc_pkg::OFF_BIT] == st.off &&
                  o_sfr_rdata[rvc_pkg::POL_BIT] == st.pol &&
                  o_sfr_rdata[rvc_pkg::LOWPWR_BIT] == st.lowpwr))
    else $error("control fields read back wrong");

  // reserved bits, other addresses and holding of the low-power select
  a_other_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !ctrl_hit |-> o_sfr_rdata == 8'h00)
    else $error("read of another address not zero");
  a_reserved_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ctrl_wr |=> (o_sfr_rdata & rvc_pkg::RESERVED_MASK) == 8'h00)
    else $error("reserved bits stored by a write");
  a_lowpwr_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !ctrl_wr |=> $stable(st.lowpwr))
    else $error("low power select changed without write");
endmodule
`default_nettype wire

// ### rtl/rvc_pkg.sv
// package: register map and field layout of the regulator and bus-power control block
package rvc_pkg;
  // ===========================================================================
  // register map
  localparam logic [7:0] CTRL_ADDR     = 8'hC9;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  // ===========================================================================
  // field positions
  localparam int         OFF_BIT       = 7;
  localparam int         LEVEL_BIT     = 6;
  localparam int         POL_BIT       = 5;
  localparam int         LOWPWR_BIT    = 4;
  localparam logic [7:0] RESERVED_MASK = 8'h0F;
  // ===========================================================================
  // bus-power input synchroniser depth
  localparam int         SYNC_STAGES   = 2;
endpackage

// ### tb/rvc_vbus_model.sv
// bus-power line as the host presents it
`timescale 1ns/1ps
`default_nettype none
module rvc_vbus_model (
  input  wire logic i_ref_clk,
  input  wire logic i_plug,
  output logic      o_bus_power
);
  always @(negedge i_ref_clk) o_bus_power <= i_plug;
endmodule
`default_nettype wire

// ### tb/regulator_vbus_control_tb_top.sv
// testbench of the regulator and bus-power control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin n_tests++; if ((a)!==(e)) begin n_errors++; \
  $display("Error t=%0t got=%h exp=%h",$time,a,e); end end
module regulator_vbus_control_tb_top;
  logic       c, r, w, p, en, sr, bp, off, on, lp, irq, rq;
  logic [7:0] a, d, q;
  int         n_errors, n_tests;
  rvc_vbus_model rvc_vbus_model_inst (.i_ref_clk(c), .i_plug(p), .o_bus_power(bp));
  rvc_regulator_vbus_control rvc_regulator_vbus_control_inst (.i_ref_clk(c),
    .i_rstn(r), .i_sfr_addr(a), .i_sfr_wr(w), .i_sfr_wdata(d), .o_sfr_rdata(q),
    .i_bus_power(bp), .i_irq_enable(en), .i_usb_reset_source(sr),
    .o_regulator_off_select(off), .o_regulator_on_select(on),
    .o_regulator_low_power_select(lp), .o_bus_power_irq(irq),
    .o_bus_power_reset_req(rq));
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge c) begin a <= ad; d <= v; w <= 1'b1; end
    @(posedge c) w <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge c) a <= ad;
    #1 `CHK(q, e)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    c = 0;
    forever #2 c = ~c;
  end
  initial begin
    #4000 n_errors++;
    results;
  end
  initial begin
    {r, w, p, en, sr, a, d} = '0;
    repeat (8) @(posedge c);
    r <= 1'b1;
    rd(8'hC9, 8'h00);
    `CHK({off, on, lp}, 3'b010)
    $display("reset test done");
    wr(8'hC9, 8'hFF);
    rd(8'hC9, 8'hB0);
    `CHK({off, on, lp}, 3'b101)
    wr(8'hC8, 8'h00);
    rd(8'hC8, 8'h00);
    `CHK(off, 1'b1)
    wr(8'hC9, 8'h20);
    #1 `CHK({off, on, lp}, 3'b010)
    $display("register test done");
    p <= 1'b1;
    en <= 1'b1;
    sr <= 1'b1;
    repeat (4) @(posedge c);
    rd(8'hC9, 8'h60);
    `CHK(irq, 1'b1)
    `CHK(rq, 1'b1)
    p <= 1'b0;
    repeat (4) @(posedge c);
    #1 `CHK({irq, rq}, 2'b00)
    $display("bus power test done");
    @(posedge c) en <= 1'b0;
    wr(8'hC9, 8'h00);
    #1 `CHK({irq, rq}, 2'b01)
    @(posedge c) en <= 1'b1;
    #1 `CHK(irq, 1'b1)
    @(posedge c) p <= 1'b1;
    repeat (4) @(posedge c);
    #1 `CHK({irq, rq}, 2'b00)
    $display("polarity test done");
    results;
  end
endmodule
`default_nettype wire
